//--- dv/fidsr_host_model.sv
// Host controller model: frames, serial clock, lane drive, capture.
// The bench resolves the pin levels from the device's enables alone.
`timescale 1ns/1ps
module fidsr_host_model (
  // Link pins driven by the host
  output logic            o_sclk,
  output logic            o_cs_n,
  output logic      [3:0] o_io,
  // Resolved pin levels
  input  wire logic [3:0] i_io
);
  // Chip select starts low and rises just after time zero. A clean edge
  // clears the frame counters and drivers, which a time-zero step may miss.
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b0;
    o_io   = 4'h0;
    #1 o_cs_n = 1'b1;
  end

  // chip select low for whole frame, raised half a clock after the last falling edge
  // Clock stands still outside frames; released lanes toggle every clock
  task automatic frame(input logic [3:0] tx[$], input int nclk, output logic [3:0] rx[$]);
    rx = {};
    // Half-nanosecond skew keeps link edges off the system clock's edges
    #0.5 o_cs_n = 1'b0;
    #8;
    for (int k = 0; k < nclk; k++) begin
      #1 o_io = (k < tx.size()) ? tx[k] : ~o_io;
      #15 o_sclk = 1'b1;
      rx.push_back(i_io);
      #16 o_sclk = 1'b0;
    end
    #16 o_cs_n = 1'b1;
    o_io = ~o_io;
    #39.5;
  endtask
endmodule // fidsr_host_model

//--- dv/fidsr_top_props.sv
// Checker for the flash identification and security-area block.
// Sees only the top ports; bound into every fidsr_top instance.
`timescale 1ns/1ps
module fidsr_top_props #(
  parameter int ERASE_TIME_US = 1
) (
  // System side
  input wire logic       I_CLK,
  input wire logic       I_RESET,
  input wire logic       I_WEL_SET,
  input wire logic [2:0] I_SEC_LOCK,
  input wire logic       O_WEL,
  input wire logic       O_BUSY,
  input wire logic [9:0] I_SEC_RD_ADDR,
  input wire logic [7:0] O_SEC_RD_DATA,
  // Link side
  input wire logic       I_SCLK,
  input wire logic       I_CS_N,
  input wire logic [3:0] I_IO,
  input wire logic [3:0] O_IO,
  input wire logic [3:0] O_IO_OE
);
  localparam int LEN_LO = ERASE_TIME_US * 250 + 255;
  localparam int LEN_HI = ERASE_TIME_US * 250 + 257;
  logic [6:0] edge_cnt;
  logic [7:0] opc;
  int         busy_cnt;

  ////////////////////////////////////////////////////////////
  // Edge count and opcode, cleared by chip select as the device's edge count is
  always_ff @(posedge I_SCLK or posedge I_CS_N) begin
    if (I_CS_N) begin
      edge_cnt <= 7'h00;
      opc      <= 8'h00;
    end else begin
      edge_cnt <= (edge_cnt == 7'h7f) ? edge_cnt : edge_cnt + 7'h01;
      opc      <= (edge_cnt < 7'h08) ? {opc[6:0], I_IO[0]} : opc;
    end
  end

  // Busy length; saturation not needed, erase is short in sim
  always_ff @(posedge I_CLK) begin
    busy_cnt <= (I_RESET || !O_BUSY) ? 0 : busy_cnt + 1;
  end

  // First single-lane bit lands after the last address edge
  sequence s_id1_first;
    O_IO_OE == 4'h0 ##1 O_IO_OE == 4'h2;
  endsequence

  ////////////////////////////////////////////////////////////
  AST_OE_IDLE: assert property (@(posedge I_CLK) disable iff (I_RESET)
    I_CS_N && $past(I_CS_N) |-> O_IO_OE == 4'h0 && O_IO == 4'h0)
    else $error("drivers on while chip select high");
  AST_OPC_SILENT: assert property (@(posedge I_SCLK) disable iff (I_CS_N)
    edge_cnt < 7'h08 |-> O_IO_OE == 4'h0)
    else $error("output during opcode");
  AST_WRITE_SILENT: assert property (@(posedge I_SCLK) disable iff (I_CS_N)
    (opc == 8'h44 || opc == 8'h42) && edge_cnt > 7'h08 |-> O_IO_OE == 4'h0)
    else $error("output during erase or program");
  AST_ID1_START: assert property (@(posedge I_SCLK) disable iff (I_CS_N)
    opc == 8'h90 && edge_cnt == 7'h1f |-> s_id1_first)
    else $error("single id output mistimed");
  AST_ID2_LANES: assert property (@(posedge I_SCLK) disable iff (I_CS_N)
    opc == 8'h92 && edge_cnt > 7'h18 |-> O_IO_OE == 4'h3)
    else $error("dual id lanes wrong");
  AST_ID4_LANES: assert property (@(posedge I_SCLK) disable iff (I_CS_N)
    opc == 8'h94 && edge_cnt > 7'h14 |-> O_IO_OE == 4'hf)
    else $error("quad id lanes wrong");
  AST_BUSY_WEL: assert property (@(posedge I_CLK) disable iff (I_RESET)
    $rose(O_BUSY) |-> O_WEL)
    else $error("erase started without latch");
  AST_BUSY_CS: assert property (@(posedge I_CLK) disable iff (I_RESET)
    $rose(O_BUSY) |-> $past(I_CS_N, 3))
    else $error("erase started before chip select rose");
  AST_BUSY_LEN: assert property (@(posedge I_CLK) disable iff (I_RESET)
    $fell(O_BUSY) |-> busy_cnt >= LEN_LO && busy_cnt <= LEN_HI)
    else $error("erase time wrong");
  AST_WEL_CLEAR: assert property (@(posedge I_CLK) disable iff (I_RESET)
    $fell(O_BUSY) && !$past(I_WEL_SET) |-> !O_WEL)
    else $error("latch kept after erase");
endmodule // fidsr_top_props

bind fidsr_top fidsr_top_props #(.ERASE_TIME_US(ERASE_TIME_US)) i_fidsr_top_props (
  .I_CLK(I_CLK), .I_RESET(I_RESET), .I_WEL_SET(I_WEL_SET), .I_SEC_LOCK(I_SEC_LOCK),
  .O_WEL(O_WEL), .O_BUSY(O_BUSY), .I_SEC_RD_ADDR(I_SEC_RD_ADDR),
  .O_SEC_RD_DATA(O_SEC_RD_DATA), .I_SCLK(I_SCLK), .I_CS_N(I_CS_N), .I_IO(I_IO),
  .O_IO(O_IO), .O_IO_OE(O_IO_OE));

//--- dv/tb_top.sv
// Self-checking bench for the identification and security-area block.
// Host model drives the link; the bench drives the system side.
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0]  MFR = 8'ha7;                // Arbitrary value
  localparam logic [7:0]  DEV = 8'h3e;                // Arbitrary value
  localparam logic [7:0]  MTY = 8'h42;                // Arbitrary value
  localparam logic [7:0]  CAP = 8'h19;                // Arbitrary value
  localparam logic [63:0] UID = 64'hfedc_ba98_7654_3210; // Arbitrary value
  logic       clk, rst, sclk, cs_n, wel_set, write_enable_latch, busy;
  logic [3:0] io, host_drv, dev_io, dev_oe;
  logic [2:0] lock;
  logic [9:0] rd_addr;
  logic [7:0] rd_data;
  logic [3:0] txq[$];
  logic [3:0] rxq[$];
  int         failures;
  int         tests_run;

  // Pin level from whoever enables it
  assign io = (dev_oe & dev_io) | (~dev_oe & host_drv);

  fidsr_top #(.MFR_CODE(MFR), .DEV_CODE(DEV), .MEM_TYPE(MTY), .CAPACITY(CAP),
    .UNIQUE_ID(UID), .ERASE_TIME_US(1)) i_fidsr_top (
    .I_CLK(clk), .I_RESET(rst), .I_SCLK(sclk), .I_CS_N(cs_n), .I_IO(io),
    .O_IO(dev_io), .O_IO_OE(dev_oe), .I_WEL_SET(wel_set), .I_SEC_LOCK(lock),
    .O_WEL(write_enable_latch), .O_BUSY(busy), .I_SEC_RD_ADDR(rd_addr), .O_SEC_RD_DATA(rd_data));
  fidsr_host_model i_fidsr_host_model (.o_sclk(sclk), .o_cs_n(cs_n), .o_io(host_drv), .i_io(io));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////
  // Compare tasks and helpers
  task automatic chk64(input string name, input logic [63:0] exp, input logic [63:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chk1(input string name, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic put_byte(input logic [7:0] v);
    for (int b = 7; b >= 0; b--) txq.push_back({3'b000, v[b]});
  endtask
  task automatic put_adr(input logic [23:0] v, input int lanes);
    for (int b = 23; b >= 0; b -= lanes)
      txq.push_back(lanes == 4 ? v[b -: 4] : lanes == 2 ? {2'b00, v[b -: 2]} : {3'b000, v[b]});
  endtask
  function automatic logic [63:0] get_bits(input int start, input int lanes, input int nbits);
    logic [63:0] v;
    v = '0;
    for (int k = start; k < start + nbits / lanes; k++)
      v = (v << lanes) | (lanes == 4 ? rxq[k] : lanes == 2 ? rxq[k][1:0] : rxq[k][1]);
    return v;
  endfunction
  task automatic set_wel();
    @(posedge clk) #1 wel_set = 1'b1;
    @(posedge clk) #1 wel_set = 1'b0;
  endtask
  task automatic peek(input logic [9:0] a, input logic [7:0] exp);
    @(posedge clk) #1 rd_addr = a;
    repeat (2) @(posedge clk);
    #1 chk64("area byte", exp, rd_data);
  endtask
  task automatic erase(input logic [23:0] adr, input int extra, input logic exp_busy);
    int n;
    txq = {};
    put_byte(8'h44);
    put_adr(adr, 1);
    i_fidsr_host_model.frame(txq, 32 + extra, rxq);
    for (n = 0; busy !== 1'b1 && n < 20; n++) @(posedge clk);
    chk1("busy start", exp_busy, busy);
    if (exp_busy) begin
      t_ident();
      chk1("busy held", 1'b1, busy);
    end
    for (n = 0; busy === 1'b1 && n < 2000; n++) @(posedge clk);
    chk1("busy end", 1'b0, busy);
  endtask
  task automatic prog(input logic [23:0] adr, input logic [7:0] d[$]);
    txq = {};
    put_byte(8'h42);
    put_adr(adr, 1);
    foreach (d[i]) put_byte(d[i]);
    i_fidsr_host_model.frame(txq, 32 + 8 * d.size(), rxq);
  endtask

  ////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_id_reads();
    int lanes;
    int start;
    for (int m = 0; m < 3; m++) begin
      lanes = 1 << m;
      start = (m == 0) ? 32 : (m == 1) ? 24 : 20;
      txq = {};
      put_byte(m == 0 ? 8'h90 : m == 1 ? 8'h92 : 8'h94);
      put_adr(24'h000000, lanes);
      // mode bits with upper nibble ones
      if (m == 1) txq = {txq, 4'h3, 4'h3, 4'h0, 4'h0};
      if (m == 2) txq = {txq, 4'hf, 4'h0};
      i_fidsr_host_model.frame(txq, start + 32 / lanes, rxq);
      chk64("id stream", {32'h0, MFR, DEV, MFR, DEV}, get_bits(start, lanes, 32));
    end
  endtask
  task automatic t_uid();
    txq = {};
    put_byte(8'h4b);
    put_adr(24'h000000, 1);
    put_byte(8'h00);
    i_fidsr_host_model.frame(txq, 104, rxq);
    chk64("unique id", UID, get_bits(40, 1, 64));
  endtask
  task automatic t_ident();
    txq = {};
    put_byte(8'h9f);
    i_fidsr_host_model.frame(txq, 32, rxq);
    chk64("ident", {40'h0, MFR, MTY, CAP}, get_bits(8, 1, 24));
  endtask
  task automatic t_ptab();
    for (int a = 0; a < 2; a++) begin
      txq = {};
      put_byte(8'h5a);
      put_adr(a == 0 ? 24'h000000 : 24'h000001, 1);
      put_byte(8'h00);
      i_fidsr_host_model.frame(txq, 64, rxq);
      chk64("table", a == 0 ? 64'h53_4644 : 64'h46_4450, get_bits(40, 1, 24));
    end
  endtask
  task automatic t_erase();
    set_wel();
    erase(24'h001000, 0, 1'b1);
    chk1("latch after erase", 1'b0, write_enable_latch);
    peek(10'h000, 8'hff);
    peek(10'h0ff, 8'hff);
  endtask
  task automatic t_refused();
    erase(24'h002000, 0, 1'b0);
    set_wel();
    erase(24'h002000, 1, 1'b0);
    erase(24'h004000, 0, 1'b0);
    @(posedge clk) #1 lock = 3'b100;
    erase(24'h003000, 0, 1'b0);
    chk1("latch kept", 1'b1, write_enable_latch);
    erase(24'h002055, 0, 1'b1);
  endtask
  task automatic t_prog();
    set_wel();
    prog(24'h0020fe, '{8'ha5, 8'h3c, 8'h0f});
    peek(10'h1fe, 8'ha5);
    peek(10'h1ff, 8'h3c);
    peek(10'h100, 8'h0f);
    prog(24'h002010, '{8'h00});
    peek(10'h110, 8'hff);
    @(posedge clk) #1 lock = 3'b110;
    set_wel();
    prog(24'h002020, '{8'h00});
    peek(10'h120, 8'hff);
  endtask

  ////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (failures == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run of about 29 us
  initial begin
    #400000;
    failures++;
    print_verdict();
  end

  initial begin
    failures = 0;
    tests_run = 0;
    rst = 1'b0;
    wel_set = 1'b0;
    lock = 3'b000;
    rd_addr = 10'h000;
    // Reset rises after time zero so the link flops see a real edge
    #1 rst = 1'b1;
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    repeat (3) @(posedge clk);
    t_id_reads();
    t_uid();
    t_ident();
    t_ptab();
    t_erase();
    t_refused();
    t_prog();
    print_verdict();
  end
endmodule // tb_top

//--- rtl/fidsr_defines.svh
// Constants of the flash identification and security-area command block.
// Macros only; included by the design modules that need them.
`ifndef FIDSR_DEFINES_SVH
`define FIDSR_DEFINES_SVH

// Instruction codes
`define FIDSR_OP_ID1       8'h90
`define FIDSR_OP_ID2       8'h92
`define FIDSR_OP_ID4       8'h94
`define FIDSR_OP_UID       8'h4b
`define FIDSR_OP_IDENT     8'h9f
`define FIDSR_OP_PTAB      8'h5a
`define FIDSR_OP_ERASE     8'h44
`define FIDSR_OP_PROG      8'h42

// Rising edges seen before the first output clock or data bit
`define FIDSR_START_ID1    6'h20
`define FIDSR_START_ID2    6'h18
`define FIDSR_START_ID4    6'h14
`define FIDSR_START_UID    6'h28
`define FIDSR_START_IDENT  6'h08
`define FIDSR_START_PTAB   6'h28
`define FIDSR_START_DATA   6'h20
`define FIDSR_START_NONE   6'h3f

// Phase ends, in rising edges since chip select fell
`define FIDSR_OPC_END      6'h08
`define FIDSR_ADDR_END1    6'h20
`define FIDSR_ADDR_END2    6'h14
`define FIDSR_ADDR_END4    6'h0e
`define FIDSR_ERASE_LAST   6'h1f
`define FIDSR_CYC_MAX      6'h3f

// Security area select field, byte and storage limits
`define FIDSR_AREA_MIN     4'h1
`define FIDSR_AREA_MAX     4'h3
`define FIDSR_BYTE_LAST    3'h7
`define FIDSR_WIPE_LAST    8'hff
`define FIDSR_ERASED       8'hff
`define FIDSR_MEM_END      10'h300

// Output enable patterns per lane width
`define FIDSR_OE_1         4'h2
`define FIDSR_OE_2         4'h3
`define FIDSR_OE_4         4'hf

// System clock period in ns
`define FIDSR_CLK_NS       4

`endif

//--- rtl/fidsr_param_rom.sv
// Constant discoverable-parameter table, 256 bytes, byte addressed.
// Purely combinational; read from the serial clock's falling edge.
`timescale 1ns/1ps
module fidsr_param_rom (
  // Byte offset in, table byte out
  input  wire logic [7:0] i_addr,
  output logic      [7:0] o_data
);

  // Signature, then one parameter_table_header; unused bytes read erased
  always_comb begin
    unique case (i_addr)
      8'h00:   o_data = 8'h53;
      8'h01:   o_data = 8'h46;
      8'h02:   o_data = 8'h44;
      8'h03:   o_data = 8'h50;
      8'h04:   o_data = 8'h06;
      8'h05:   o_data = 8'h01;
      8'h06:   o_data = 8'h00;
      8'h08:   o_data = 8'h00;
      8'h09:   o_data = 8'h06;
      8'h0a:   o_data = 8'h01;
      8'h0b:   o_data = 8'h10;
      8'h0c:   o_data = 8'h80;
      8'h0d:   o_data = 8'h00;
      8'h0e:   o_data = 8'h00;
      default: o_data = 8'hff;
    endcase
  end

endmodule // fidsr_param_rom

//--- rtl/fidsr_pkg.sv
// Types shared by the flash identification and security-area block.
// Compiled before every module that imports it.
package fidsr_pkg;

  // Erase sequencer, Gray coded along idle, wait, wipe
  typedef enum logic [1:0] {
    FIDSR_IDLE = 2'b00,
    FIDSR_WAIT = 2'b01,
    FIDSR_WIPE = 2'b11
  } fidsr_state_e;

  // Data lanes used by the current instruction
  typedef enum logic [1:0] {
    FIDSR_LANE_1 = 2'b00,
    FIDSR_LANE_2 = 2'b01,
    FIDSR_LANE_4 = 2'b10
  } fidsr_lane_e;

endpackage

//--- rtl/fidsr_sync.sv
// Two-flop synchroniser for one level into the system clock domain.
// Assumes a synchronous active-high reset on the destination clock.
`timescale 1ns/1ps
module fidsr_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  // Destination clock and reset
  input  wire logic i_clk,
  input  wire logic i_reset,
  // Level in and synchronised level out
  input  wire logic i_d,
  output logic      o_q
);

  logic meta;

  // First flop feeds only the second one
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      meta <= RESET_VAL;
      o_q  <= RESET_VAL;
    end else begin
      meta <= i_d;
      o_q  <= meta;
    end
  end

endmodule // fidsr_sync

//--- rtl/fidsr_top.sv
// Identification reads and security-area erase/program of a serial flash.
// Assumes the host drives I_SCLK and I_CS_N; I_SCLK stops between frames.
// What this block does
// - Opcode 90h plus zero address: manufacturer then device code, MSB first.
// - ID codes keep alternating while chip select stays low.
// - Opcode 92h: address two bits per clock, codes out two bits per clock.
// - Opcode 94h: quad address, 8 mode bits, 4 dummy clocks, quad out.
// - Opcode 4Bh plus four dummy bytes returns a fixed 64-bit unique number.
// - Opcode 9Fh returns manufacturer, memory type, capacity bytes, MSB first.
// - Opcode 5Ah: address, eight dummy clocks, table out from clock 40.
// - Three 256-byte security areas selected by address bits 15..12 = 1..3.
// - Opcode 44h erases an area only with the write enable latch set.
// - Erase is self-timed; busy reads one during it, zero afterwards.
// - Finished erase clears the write enable latch.
// - Set lock bits make their area permanent; erases to it are ignored.
// - Opcode 42h with latch set programs erased bytes from given offset.
// - Programs aimed at a locked area write nothing but still clear the latch.
`timescale 1ns/1ps
`include "fidsr_defines.svh"
module fidsr_top
  import fidsr_pkg::*;
#(
  parameter logic [7:0]  MFR_CODE      = 8'h5c,                  // Arbitrary value
  parameter logic [7:0]  DEV_CODE      = 8'h14,                  // Arbitrary value
  parameter logic [7:0]  MEM_TYPE      = 8'h60,                  // Arbitrary value
  parameter logic [7:0]  CAPACITY      = 8'h15,                  // Arbitrary value
  parameter logic [63:0] UNIQUE_ID     = 64'h0123_4567_89ab_cdef, // Arbitrary value
  parameter int          ERASE_TIME_US = 50000
) (
  // System clock and reset
  input  wire logic       I_CLK,
  input  wire logic       I_RESET,
  // Serial link from the host
  input  wire logic       I_SCLK,
  input  wire logic       I_CS_N,
  input  wire logic [3:0] I_IO,
  output logic      [3:0] O_IO,
  output logic      [3:0] O_IO_OE,
  // Status and control
  input  wire logic       I_WEL_SET,
  input  wire logic [2:0] I_SEC_LOCK,
  output logic            O_WEL,
  output logic            O_BUSY,
  // Security area inspection
  input  wire logic [9:0] I_SEC_RD_ADDR,
  output logic      [7:0] O_SEC_RD_DATA
);

  // Erase duration in system clocks, rounded up
  localparam int          ERASE_CYC  = (ERASE_TIME_US * 1000 + `FIDSR_CLK_NS - 1) / `FIDSR_CLK_NS;
  localparam logic [31:0] ERASE_LAST = 32'(ERASE_CYC - 1);

  //////////////////////////////////////////////////////////////////////////////
  // Link domain: counters, shifters, decode
  //////////////////////////////////////////////////////////////////////////////

  logic [5:0]  cyc;       // Rising edges since chip select fell, saturating
  logic [10:0] ocnt;      // Output or data clocks, wraps every 2048
  logic [7:0]  opc;
  logic [23:0] addr;
  logic [6:0]  dbits;
  logic        erase_arm;
  logic        prog_seen;
  logic        ptog;
  logic [17:0] pword;     // Area index, byte offset, data byte

  logic        op_id1;
  logic        op_id2;
  logic        op_id4;
  logic        op_uid;
  logic        op_ident;
  logic        op_ptab;
  logic        op_erase;
  logic        op_prog;
  logic        out_en;
  fidsr_lane_e lane;
  logic [5:0]  start;
  logic [5:0]  addr_end;
  logic        past_start;
  logic        in_opc;
  logic        in_addr;
  logic        data_phase;
  logic        byte_done;
  logic        area_ok;
  logic [1:0]  area_idx;
  logic [7:0]  p_off;
  logic [5:0]  next_cyc;
  logic [10:0] next_ocnt;
  logic [23:0] next_addr;

  // Opcode decode
  assign op_id1   = opc == `FIDSR_OP_ID1;
  assign op_id2   = opc == `FIDSR_OP_ID2;
  assign op_id4   = opc == `FIDSR_OP_ID4;
  assign op_uid   = opc == `FIDSR_OP_UID;
  assign op_ident = opc == `FIDSR_OP_IDENT;
  assign op_ptab  = opc == `FIDSR_OP_PTAB;
  assign op_erase = opc == `FIDSR_OP_ERASE;
  assign op_prog  = opc == `FIDSR_OP_PROG;
  assign out_en   = op_id1 | op_id2 | op_id4 | op_uid | op_ident | op_ptab;

  // Lane width and phase boundaries per instruction
  assign lane = op_id4 ? FIDSR_LANE_4 : (op_id2 ? FIDSR_LANE_2 : FIDSR_LANE_1);
  assign start = op_id1   ? `FIDSR_START_ID1   :
                 op_id2   ? `FIDSR_START_ID2   :
                 op_id4   ? `FIDSR_START_ID4   :
                 op_uid   ? `FIDSR_START_UID   :
                 op_ident ? `FIDSR_START_IDENT :
                 op_ptab  ? `FIDSR_START_PTAB  :
                 op_prog  ? `FIDSR_START_DATA  : `FIDSR_START_NONE;
  assign addr_end = (lane == FIDSR_LANE_4) ? `FIDSR_ADDR_END4 :
                    (lane == FIDSR_LANE_2) ? `FIDSR_ADDR_END2 : `FIDSR_ADDR_END1;

  // Phase flags; opcode is final once eight edges are in
  assign in_opc     = cyc < `FIDSR_OPC_END;
  assign past_start = !in_opc && (cyc >= start);
  assign in_addr    = !in_opc && (cyc < addr_end);
  assign data_phase = op_prog && past_start;
  assign byte_done  = data_phase && (ocnt[2:0] == `FIDSR_BYTE_LAST);

  // Area select: bits 15..12 give 1..3, bits 23..16 and 11..8 zero
  assign area_ok  = (addr[23:16] == 8'h00) && (addr[11:8] == 4'h0) &&
                    (addr[15:12] >= `FIDSR_AREA_MIN) && (addr[15:12] <= `FIDSR_AREA_MAX);
  assign area_idx = addr[13:12] - 2'h1;

  // Offset wraps inside the 256-byte area
  assign p_off = addr[7:0] + ocnt[10:3];

  // Counter steps; ocnt only runs once output or data has begun
  assign next_cyc  = (cyc == `FIDSR_CYC_MAX) ? cyc : cyc + 6'h01;
  assign next_ocnt = (past_start && (out_en || op_prog)) ? ocnt + 11'h001 : ocnt;

  // Address taken one, two or four bits per clock, MSB first
  assign next_addr = (lane == FIDSR_LANE_4) ? {addr[19:0], I_IO[3:0]} :
                     (lane == FIDSR_LANE_2) ? {addr[21:0], I_IO[1:0]} :
                                              {addr[22:0], I_IO[0]};

  // Frame counters; chip select high clears them without a clock edge
  always_ff @(posedge I_SCLK or posedge I_CS_N) begin
    if (I_CS_N) begin
      cyc  <= 6'h00;
      ocnt <= 11'h000;
    end else begin
      cyc  <= next_cyc;
      ocnt <= next_ocnt;
    end
  end

  // Opcode, address and data sampled on rising edge
  always_ff @(posedge I_SCLK or posedge I_RESET) begin
    if (I_RESET) begin
      opc   <= 8'h00;
      addr  <= 24'h000000;
      dbits <= 7'h00;
    end else begin
      if (in_opc) opc <= {opc[6:0], I_IO[0]};
      if (in_addr) addr <= next_addr;
      if (data_phase) dbits <= {dbits[5:0], I_IO[0]};
    end
  end

  // Armed only when exactly 32 edges were taken
  always_ff @(posedge I_SCLK or posedge I_RESET) begin
    if (I_RESET) begin
      erase_arm <= 1'b0;
    end else begin
      erase_arm <= op_erase && (cyc == `FIDSR_ERASE_LAST);
    end
  end

  // Each whole data byte inside an area is handed over by a toggle
  always_ff @(posedge I_SCLK or posedge I_RESET) begin
    if (I_RESET) begin
      ptog      <= 1'b0;
      pword     <= 18'h00000;
      prog_seen <= 1'b0;
    end else begin
      if (cyc == 6'h00) prog_seen <= 1'b0;
      else if (byte_done) prog_seen <= 1'b1;
      if (byte_done && area_ok) begin
        pword <= {area_idx, p_off, dbits, I_IO[0]};
        ptog  <= ~ptog;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Link domain: falling-edge output
  //////////////////////////////////////////////////////////////////////////////

  logic [7:0]  ptab_byte;
  logic [63:0] src;
  logic [5:0]  bitpos;
  logic [63:0] shifted;
  logic [3:0]  next_io;
  logic [3:0]  next_oe;

  // Table offset from the low address byte, rolling per byte
  fidsr_param_rom u_rom (
    .i_addr (p_off),
    .o_data (ptab_byte)
  );

  // Identity bytes in order; unique number
  assign src = op_uid   ? UNIQUE_ID :
               op_ident ? {MFR_CODE, MEM_TYPE, CAPACITY, 40'h0} :
               op_ptab  ? {ptab_byte, 56'h0} :
                          {4{MFR_CODE, DEV_CODE}};

  // Position repeats every 64 bits, so the codes alternate
  assign bitpos = op_ptab                ? {3'h0, ocnt[2:0]} :
                  (lane == FIDSR_LANE_4) ? {ocnt[3:0], 2'h0} :
                  (lane == FIDSR_LANE_2) ? {ocnt[4:0], 1'h0} : ocnt[5:0];
  assign shifted = src << bitpos;

  // Single lane drives the output pin IO1 only
  assign next_io = (lane == FIDSR_LANE_4) ? shifted[63:60] :
                   (lane == FIDSR_LANE_2) ? {2'h0, shifted[63:62]} :
                                            {2'h0, shifted[63], 1'b0};
  assign next_oe = (lane == FIDSR_LANE_4) ? `FIDSR_OE_4 :
                   (lane == FIDSR_LANE_2) ? `FIDSR_OE_2 : `FIDSR_OE_1;

  // Output changes on falling edges once the start count is reached
  always_ff @(negedge I_SCLK or posedge I_CS_N) begin
    if (I_CS_N) begin
      O_IO    <= 4'h0;
      O_IO_OE <= 4'h0;
    end else if (out_en && past_start) begin
      O_IO    <= next_io;
      O_IO_OE <= next_oe;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // System domain: crossings
  //////////////////////////////////////////////////////////////////////////////

  logic cs_s;
  logic cs_q;
  logic tog_s;
  logic tog_q;
  logic cs_rise;
  logic tog_edge;

  fidsr_sync #(
    .RESET_VAL (1'b1)
  ) u_cs_sync (
    .i_clk   (I_CLK),
    .i_reset (I_RESET),
    .i_d     (I_CS_N),
    .o_q     (cs_s)
  );

  fidsr_sync #(
    .RESET_VAL (1'b0)
  ) u_tog_sync (
    .i_clk   (I_CLK),
    .i_reset (I_RESET),
    .i_d     (ptog),
    .o_q     (tog_s)
  );

  // Edge detect on the synchronised levels
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      cs_q  <= 1'b1;
      tog_q <= 1'b0;
    end else begin
      cs_q  <= cs_s;
      tog_q <= tog_s;
    end
  end

  // Link flags and address are still while chip select is high,
  // so reading them at the synchronised rise is safe
  assign cs_rise  = cs_s & ~cs_q;
  assign tog_edge = tog_s ^ tog_q;

  //////////////////////////////////////////////////////////////////////////////
  // System domain: erase sequencer, latch, storage
  //////////////////////////////////////////////////////////////////////////////

  fidsr_state_e state;
  fidsr_state_e next_state;
  logic [31:0]  timer;
  logic [7:0]   wipe;
  logic [1:0]   wipe_area;
  logic         write_enable_latch;
  logic         idle;
  logic         erase_go;
  logic         prog_go;
  logic         wel_clr;
  logic [9:0]   p_index;
  logic [7:0]   mem [0:767];

  assign idle = state == FIDSR_IDLE;

  // Latch needed; locked area refused; busy refuses too
  assign erase_go = cs_rise && erase_arm && area_ok && write_enable_latch && idle && !I_SEC_LOCK[area_idx];

  assign prog_go = tog_edge && write_enable_latch && idle && !I_SEC_LOCK[pword[17:16]];
  assign p_index = {pword[17:16], pword[15:8]};

  // Latch drops when the wipe ends, or when a program frame with a whole data byte ends while idle
  assign wel_clr = ((state == FIDSR_WIPE) && (wipe == `FIDSR_WIPE_LAST)) ||
                   (cs_rise && prog_seen && op_prog && idle);

  // Wait the erase time, then wipe the area byte by byte
  always_comb begin
    next_state = state;
    unique case (state)
      FIDSR_IDLE: if (erase_go) next_state = FIDSR_WAIT;
      FIDSR_WAIT: if (timer == ERASE_LAST) next_state = FIDSR_WIPE;
      FIDSR_WIPE: if (wipe == `FIDSR_WIPE_LAST) next_state = FIDSR_IDLE;
      default:    next_state = FIDSR_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      state     <= FIDSR_IDLE;
      timer     <= 32'h0;
      wipe      <= 8'h00;
      wipe_area <= 2'h0;
    end else begin
      state <= next_state;
      timer <= (state == FIDSR_WAIT) ? timer + 32'h1 : 32'h0;
      wipe  <= (state == FIDSR_WIPE) ? wipe + 8'h01 : 8'h00;
      if (erase_go) wipe_area <= area_idx;
    end
  end

  // Set wins over clear in the same cycle
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      write_enable_latch <= 1'b0;
    end else begin
      write_enable_latch <= I_WEL_SET | (write_enable_latch & ~wel_clr);
    end
  end

  // Programming only clears bits, as on erased cells
  always_ff @(posedge I_CLK) begin
    if (state == FIDSR_WIPE) begin
      mem[{wipe_area, wipe}] <= `FIDSR_ERASED;
    end else if (prog_go) begin
      mem[p_index] <= mem[p_index] & pword[7:0];
    end
  end

  // Inspection read, one cycle latency; beyond the areas reads zero
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      O_SEC_RD_DATA <= 8'h00;
    end else if (I_SEC_RD_ADDR < `FIDSR_MEM_END) begin
      O_SEC_RD_DATA <= mem[I_SEC_RD_ADDR];
    end else begin
      O_SEC_RD_DATA <= 8'h00;
    end
  end

  assign O_BUSY = !idle;
  assign O_WEL  = write_enable_latch;

endmodule // fidsr_top
